// ### verilog/pack_status_pkg.sv
package pack_status_pkg;
    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h16;
    localparam logic [7:0] CMD_CYCLE_COUNT = 8'h17;
    // ==========================================================
    // status word masks
    localparam logic [15:0] M_OVER_CHARGED = 16'h8000;
    localparam logic [15:0] M_TERM_CHARGE = 16'h4000;
    localparam logic [15:0] M_OVER_TEMP = 16'h1000;
    localparam logic [15:0] M_TERM_DISCHARGE = 16'h0800;
    localparam logic [15:0] M_LOW_CAPACITY = 16'h0200;
    localparam logic [15:0] M_LOW_TIME = 16'h0100;
    localparam logic [15:0] M_INITIALIZED = 16'h0080;
    localparam logic [15:0] M_DISCHARGING = 16'h0040;
    localparam logic [15:0] M_FULLY_CHARGED = 16'h0020;
    localparam logic [15:0] M_FULLY_DISCHARGED = 16'h0010;
    localparam logic [15:0] M_ERROR_FIELD = 16'h0007;
    // reserved bits 0x2000, 0x0400, 0x0008 never set
    localparam logic [15:0] M_IMPLEMENTED = 16'hDBF7;
    // ==========================================================
    // error codes
    localparam logic [2:0] ERR_OK = 3'h0;
    localparam logic [2:0] ERR_BUSY = 3'h1;
    localparam logic [2:0] ERR_RESERVED = 3'h2;
    localparam logic [2:0] ERR_UNSUPPORTED = 3'h3;
    localparam logic [2:0] ERR_ACCESS = 3'h4;
    localparam logic [2:0] ERR_OVERFLOW = 3'h5;
    localparam logic [2:0] ERR_BAD_SIZE = 3'h6;
    localparam logic [2:0] ERR_UNKNOWN = 3'h7;
    // ==========================================================
    // fixed values
    localparam logic [15:0] WORD_MAX = 16'hFFFF;
    localparam logic [15:0] CV_CURRENT_SOURCE = 16'hFFFF;
    localparam logic [6:0] DISCHARGED_CLEAR_PCT = 7'd20;
    localparam logic [15:0] OVERCHARGE_RELEASE_MAH = 16'h0002;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // command outcome classes from the bus front end
    typedef enum logic [2:0] {
        OUT_OK, OUT_BUSY, OUT_RESERVED, OUT_UNSUPPORTED,
        OUT_READ_ONLY, OUT_OVERFLOW, OUT_BAD_SIZE, OUT_OTHER
    } outcome_t;
endpackage

// ### verilog/hyst_flag.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// set/clear flag, set wins over clear
module hyst_flag (
    input wire logic clock,
    input wire logic rst,
    input wire logic set_cond,
    input wire logic clr_cond,
    output logic flag
);
    logic flag_q; // held flag
    logic flag_d; // next flag
    // set has priority
    always_comb begin
        flag_d = flag_q;
        if (clr_cond) begin
            flag_d = 1'b0;
        end
        if (set_cond) begin
            flag_d = 1'b1;
        end
    end
    // register
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag = flag_q;
endmodule
`default_nettype wire

// ### verilog/sat_counter.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// saturating counter with loadable start value
module sat_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic inc,
    output logic [WIDTH-1:0] count,
    output logic stepped
);
    logic [WIDTH-1:0] count_q; // held count
    logic [WIDTH-1:0] count_d; // next count
    logic stepped_q; // one-cycle increment pulse
    logic stepped_d;
    // next count, sticks at all ones
    always_comb begin
        count_d = count_q;
        stepped_d = 1'b0;
        if (load) begin
            count_d = load_value;
        end else if (inc && (count_q != {WIDTH{1'b1}})) begin
            count_d = count_q + 1'b1;
            stepped_d = 1'b1;
        end
    end
    // register
    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= '0;
            stepped_q <= 1'b0;
        end else begin
            count_q <= count_d;
            stepped_q <= stepped_d;
        end
    end
    assign count = count_q;
    assign stepped = stepped_q;
endmodule
`default_nettype wire

// ### verilog/battery_status_word_logic.sv
// Operation
// - charge voltage word in mV, FFFF current-source
// - command 0x16 returns 16-bit status word
// - overcharge flag, cleared after 2 mAh idle
// - charge-termination alarm until charging stops
// - over-temperature alarm with reset thresholds
// - discharge-termination alarm set/clear conditions
// - low-capacity alarm versus host threshold
// - low-time alarm versus host threshold
// - initialized flag follows nonvolatile load validity
// - discharging flag whenever not charging
// - fully-charged on termination or overcharge
// - fully-discharged flag, cleared at 20 percent
// - three-bit error code encoding
// - busy code when command not serviceable
// - reserved code for reserved or manufacturer commands
// - unsupported code for defined unsupported commands
// - access-denied code on read-only write
// - wrong-length code on bad block size
// - alarm broadcast forces error bits high
// - capacity and time alarms follow units mode
// - command 0x17 returns cycle count, saved
// - cycle count saturates at 65535
// - units bit: mAh clear, 10 mWh set
// - relative charge is percent of learned full
`timescale 1ns/1ns
`default_nettype none
module battery_status_word_logic
    import pack_status_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    // ==========================================================
    // gauge measurements; capacity and time come in both units and the mode bit picks one
    input wire logic capacity_units_mode,
    input wire logic [WORD_W-1:0] charge_left_mah,
    input wire logic [WORD_W-1:0] charge_left_10mwh,
    input wire logic [WORD_W-1:0] full_capacity_mah,
    input wire logic [WORD_W-1:0] full_capacity_10mwh,
    input wire logic [WORD_W-1:0] mean_runtime_left_i,
    input wire logic [WORD_W-1:0] mean_runtime_left_p,
    input wire logic [WORD_W-1:0] runtime_now_i,
    input wire logic [WORD_W-1:0] runtime_now_p,
    input wire logic [WORD_W-1:0] charge_left_threshold,
    input wire logic [WORD_W-1:0] runtime_threshold,
    input wire logic [WORD_W-1:0] overcharge_margin,
    input wire logic [WORD_W-1:0] accumulated_charge,
    input wire logic charging,
    input wire logic discharge_mah_tick,
    input wire logic primary_termination,
    input wire logic [WORD_W-1:0] temperature,
    input wire logic [WORD_W-1:0] ot_charge_set,
    input wire logic [WORD_W-1:0] ot_charge_reset,
    input wire logic [WORD_W-1:0] ot_discharge_set,
    input wire logic [WORD_W-1:0] ot_discharge_reset,
    input wire logic [WORD_W-1:0] suspend_temp_low,
    input wire logic [WORD_W-1:0] pack_voltage,
    input wire logic [WORD_W-1:0] terminate_voltage,
    input wire logic [WORD_W-1:0] single_cell_voltage,
    input wire logic [WORD_W-1:0] second_end_discharge_threshold,
    input wire logic cell_undervoltage_flag,
    input wire logic below_overload_current,
    input wire logic [6:0] fully_charged_clear_pct,
    input wire logic [6:0] battery_low_pct,
    input wire logic nv_load_valid,
    input wire logic nv_load_bad,
    input wire logic [WORD_W-1:0] requested_charge_voltage_mv,
    input wire logic cv_out_of_range,
    input wire logic cycle_threshold_hit,
    input wire logic cycle_load,
    input wire logic [WORD_W-1:0] cycle_load_value,
    // ==========================================================
    // command side of the bus front end
    input wire logic cmd_done,
    input wire logic [2:0] cmd_outcome,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_command,
    input wire logic broadcast_req,
    output logic [WORD_W-1:0] rd_data,
    output logic rd_valid,
    output logic [WORD_W-1:0] alarm_broadcast,
    output logic alarm_broadcast_valid,
    output logic [WORD_W-1:0] pack_status_word,
    output logic [WORD_W-1:0] charge_cycle_counter,
    output logic cycle_save_req
);
    // ==========================================================
    // unit selection
    logic [WORD_W-1:0] cap_left; // remaining capacity, chosen units
    logic [WORD_W-1:0] cap_full; // learned full capacity
    logic [WORD_W-1:0] tte_avg; // average time to empty
    logic [WORD_W-1:0] tte_now; // time at present rate
    logic [6:0] rel_pct; // relative state of charge
    logic [WORD_W:0] over_limit; // full plus margin, one bit wider
    logic [WORD_W+6:0] pct_prod; // scaled remaining capacity
    logic [WORD_W-1:0] cap_left_q; // previous remaining capacity
    logic [WORD_W-1:0] tte_q; // previous average time
    logic [WORD_W-1:0] oc_idle_q; // mAh seen since charging stopped
    logic [WORD_W-1:0] oc_idle_d;
    // mode bit picks mAh or 10 mWh figures
    always_comb begin
        cap_left = capacity_units_mode ? charge_left_10mwh
                                       : charge_left_mah;
        cap_full = capacity_units_mode ? full_capacity_10mwh
                                       : full_capacity_mah;
        tte_avg = capacity_units_mode ? mean_runtime_left_p
                                      : mean_runtime_left_i;
        tte_now = capacity_units_mode ? runtime_now_p
                                      : runtime_now_i;
        over_limit = {1'b0, cap_full} + {1'b0, overcharge_margin};
        pct_prod = {7'd0, cap_left} * (WORD_W + 7)'(100);
    end
    // percent of learned full capacity, whole numbers
    always_comb begin
        if (cap_full == '0) begin
            rel_pct = 7'd0;
        end else if ((pct_prod / cap_full) > (WORD_W + 7)'(100)) begin
            rel_pct = 7'd100;
        end else begin
            rel_pct = 7'((pct_prod / cap_full));
        end
    end
    // ==========================================================
    // overcharge release counter
    always_comb begin
        oc_idle_d = oc_idle_q;
        if (charging) begin
            oc_idle_d = '0;
        end else if (discharge_mah_tick
                     && oc_idle_q != OVERCHARGE_RELEASE_MAH) begin
            oc_idle_d = oc_idle_q + 1'b1;
        end
    end
    // history registers
    always_ff @(posedge clock) begin
        if (rst) begin
            oc_idle_q <= '0;
            cap_left_q <= '0;
            tte_q <= '0;
        end else begin
            oc_idle_q <= oc_idle_d;
            cap_left_q <= cap_left;
            tte_q <= tte_avg;
        end
    end
    // ==========================================================
    // flag conditions
    logic set_oc, clr_oc, set_tc, set_ot, clr_ot, set_td, clr_td;
    logic set_lc, clr_lc, set_lt, clr_lt, set_fc, clr_fc;
    logic set_fd, clr_fd;
    logic f_oc, f_tc, f_ot, f_td, f_lc, f_lt, f_in, f_fc, f_fd;
    always_comb begin
        set_oc = charging
                 && ({1'b0, accumulated_charge} > over_limit);
        clr_oc = !charging
                 && oc_idle_q == OVERCHARGE_RELEASE_MAH;
        set_tc = primary_termination;
        set_ot = charging ? (temperature >= ot_charge_set)
                          : (temperature >= ot_discharge_set);
        clr_ot = charging ? (temperature < ot_charge_reset)
                          : (temperature < ot_discharge_reset);
        set_td = (cap_left == '0) || (pack_voltage == terminate_voltage)
                 || (temperature <= suspend_temp_low)
                 || cell_undervoltage_flag;
        clr_td = (pack_voltage > terminate_voltage) && (cap_left != '0)
                 && !cell_undervoltage_flag;
        set_lc = cap_left < charge_left_threshold;
        clr_lc = (charge_left_threshold < cap_left)
                 || (charging && cap_left > cap_left_q);
        set_lt = !charging && (tte_now < runtime_threshold);
        clr_lt = (runtime_threshold < tte_avg)
                 || (charging && tte_avg > tte_q);
        set_fc = primary_termination || f_oc;
        clr_fc = rel_pct < fully_charged_clear_pct;
        set_fd = (((pack_voltage < second_end_discharge_threshold)
                  || (single_cell_voltage
                      < second_end_discharge_threshold))
                  && below_overload_current)
                 || (rel_pct < battery_low_pct);
        clr_fd = rel_pct >= DISCHARGED_CLEAR_PCT;
    end
    // ==========================================================
    // one held flag per status bit, except the discharging bit, which follows !charging directly
    hyst_flag u_oc (.clock(clock), .rst(rst), .set_cond(set_oc),
        .clr_cond(clr_oc), .flag(f_oc));
    hyst_flag u_tc (.clock(clock), .rst(rst), .set_cond(set_tc),
        .clr_cond(!charging), .flag(f_tc));
    hyst_flag u_ot (.clock(clock), .rst(rst), .set_cond(set_ot),
        .clr_cond(clr_ot), .flag(f_ot));
    hyst_flag u_td (.clock(clock), .rst(rst), .set_cond(set_td),
        .clr_cond(clr_td), .flag(f_td));
    hyst_flag u_lc (.clock(clock), .rst(rst), .set_cond(set_lc),
        .clr_cond(clr_lc), .flag(f_lc));
    hyst_flag u_lt (.clock(clock), .rst(rst), .set_cond(set_lt),
        .clr_cond(clr_lt), .flag(f_lt));
    hyst_flag u_in (.clock(clock), .rst(rst), .set_cond(nv_load_valid),
        .clr_cond(nv_load_bad), .flag(f_in));
    hyst_flag u_fc (.clock(clock), .rst(rst), .set_cond(set_fc),
        .clr_cond(clr_fc), .flag(f_fc));
    hyst_flag u_fd (.clock(clock), .rst(rst), .set_cond(set_fd),
        .clr_cond(clr_fd), .flag(f_fd));
    // ==========================================================
    // cycle counter
    logic [WORD_W-1:0] cycles; // saturating count
    logic cycle_stepped; // pulse after an increment
    sat_counter #(.WIDTH(WORD_W)) u_cycles (
        .clock(clock), .rst(rst), .load(cycle_load),
        .load_value(cycle_load_value), .inc(cycle_threshold_hit),
        .count(cycles), .stepped(cycle_stepped));
    // ==========================================================
    // error code of the last command
    logic [2:0] err_q; // last outcome
    logic [2:0] err_d;
    always_comb begin
        err_d = err_q;
        if (cmd_done) begin
            unique case (outcome_t'(cmd_outcome))
                OUT_OK: err_d = ERR_OK;
                OUT_BUSY: err_d = ERR_BUSY;
                OUT_RESERVED: err_d = ERR_RESERVED;
                OUT_UNSUPPORTED: err_d = ERR_UNSUPPORTED;
                OUT_READ_ONLY: err_d = ERR_ACCESS;
                OUT_OVERFLOW: err_d = ERR_OVERFLOW;
                OUT_BAD_SIZE: err_d = ERR_BAD_SIZE;
                OUT_OTHER: err_d = ERR_UNKNOWN;
            endcase
        end
    end
    // ==========================================================
    // assembled status word and output registers
    logic [WORD_W-1:0] status_raw; // word before masking
    logic [WORD_W-1:0] status_now; // word as read
    logic [WORD_W-1:0] rd_data_d, ab_d;
    logic rd_valid_d, ab_valid_d;
    logic [WORD_W-1:0] status_q, cycles_q, rd_data_q, ab_q;
    logic rd_valid_q, ab_valid_q, save_q;
    always_comb begin
        status_raw = (f_oc ? M_OVER_CHARGED : '0)
                     | (f_tc ? M_TERM_CHARGE : '0)
                     | (f_ot ? M_OVER_TEMP : '0)
                     | (f_td ? M_TERM_DISCHARGE : '0)
                     | (f_lc ? M_LOW_CAPACITY : '0)
                     | (f_lt ? M_LOW_TIME : '0)
                     | (f_in ? M_INITIALIZED : '0)
                     | (!charging ? M_DISCHARGING : '0)
                     | (f_fc ? M_FULLY_CHARGED : '0)
                     | (f_fd ? M_FULLY_DISCHARGED : '0)
                     | {13'd0, err_q};
        status_now = status_raw & M_IMPLEMENTED;
        rd_valid_d = rd_strobe;
        rd_data_d = rd_data_q;
        if (rd_strobe) begin
            unique case (rd_command)
                CMD_STATUS_WORD: rd_data_d = status_now;
                CMD_CYCLE_COUNT: rd_data_d = cycles;
                CMD_CHARGE_VOLTAGE: rd_data_d = cv_out_of_range
                    ? CV_CURRENT_SOURCE
                    : requested_charge_voltage_mv;
                default: rd_data_d = RESET_WORD;
            endcase
        end
        ab_valid_d = broadcast_req;
        ab_d = broadcast_req ? (status_now | M_ERROR_FIELD)
                             : ab_q;
    end
    // output flops
    always_ff @(posedge clock) begin
        if (rst) begin
            err_q <= ERR_OK;
            status_q <= RESET_WORD;
            cycles_q <= RESET_WORD;
            rd_data_q <= RESET_WORD;
            rd_valid_q <= 1'b0;
            ab_q <= RESET_WORD;
            ab_valid_q <= 1'b0;
            save_q <= 1'b0;
        end else begin
            err_q <= err_d;
            status_q <= status_now;
            cycles_q <= cycles;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            ab_q <= ab_d;
            ab_valid_q <= ab_valid_d;
            save_q <= cycle_stepped;
        end
    end
    assign pack_status_word = status_q;
    assign charge_cycle_counter = cycles_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign alarm_broadcast = ab_q;
    assign alarm_broadcast_valid = ab_valid_q;
    assign cycle_save_req = save_q;
    // ==========================================================
    // checks
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        (pack_status_word & ~M_IMPLEMENTED) == '0)
        else $error("reserved status bit set");
    a_broadcast_err: assert property (@(posedge clock) disable iff (rst)
        broadcast_req |=> alarm_broadcast[2:0] == 3'h7)
        else $error("broadcast error bits not high");
    a_err_busy: assert property (@(posedge clock) disable iff (rst)
        cmd_done && cmd_outcome == 3'h1 |=> ##1
        pack_status_word[2:0] == ERR_BUSY)
        else $error("busy code missing");
    a_err_access: assert property (@(posedge clock) disable iff (rst)
        cmd_done && cmd_outcome == 3'h4 |=> ##1
        pack_status_word[2:0] == ERR_ACCESS)
        else $error("access code missing");
    a_err_size: assert property (@(posedge clock) disable iff (rst)
        cmd_done && cmd_outcome == 3'h6 |=> ##1
        pack_status_word[2:0] == ERR_BAD_SIZE)
        else $error("size code missing");
    a_discharging_bit: assert property (@(posedge clock)
        disable iff (rst) !charging |=> pack_status_word[6])
        else $error("discharging bit wrong");
    a_cycle_saturate: assert property (@(posedge clock) disable iff (rst)
        cycles == 16'hFFFF && !cycle_load |=> cycles == 16'hFFFF)
        else $error("cycle count wrapped");
    a_cycle_save: assert property (@(posedge clock) disable iff (rst)
        cycle_threshold_hit && !cycle_load && cycles != 16'hFFFF
        |=> ##1 cycle_save_req)
        else $error("cycle save missing");
    a_status_read: assert property (@(posedge clock) disable iff (rst)
        rd_strobe && rd_command == 8'h16
        |=> rd_valid && rd_data == $past(status_now))
        else $error("status read wrong");
    a_fd_clear: assert property (@(posedge clock) disable iff (rst)
        rel_pct >= 7'd20 && !set_fd |=> !f_fd)
        else $error("discharged flag stuck");
    a_term_clear: assert property (@(posedge clock) disable iff (rst)
        !charging && !primary_termination |=> !f_tc)
        else $error("charge termination alarm stuck");
    a_oc_release: assert property (@(posedge clock) disable iff (rst)
        !charging && oc_idle_q == OVERCHARGE_RELEASE_MAH |=> !f_oc)
        else $error("overcharge alarm not released");
endmodule
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host side: word reads, command outcomes, alarm broadcasts
module host_model (
    input wire logic clock,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic [15:0] alarm_broadcast,
    input wire logic alarm_broadcast_valid,
    output logic rd_strobe,
    output logic [7:0] rd_command,
    output logic cmd_done,
    output logic [2:0] cmd_outcome,
    output logic broadcast_req
);
    // idle bus at time zero
    initial begin
        rd_strobe = 1'b0;
        rd_command = 8'h00;
        cmd_done = 1'b0;
        cmd_outcome = 3'h0;
        broadcast_req = 1'b0;
    end
    // one-cycle request, then a bounded wait for the answer
    task automatic request(input logic bc, input logic [7:0] cmd,
                           output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(negedge clock);
        rd_strobe = !bc;
        broadcast_req = bc;
        rd_command = cmd;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            rd_strobe = 1'b0;
            broadcast_req = 1'b0;
            // released command lines never keep the stale value
            rd_command = ~cmd;
            if (!ok && (bc ? alarm_broadcast_valid : rd_valid) === 1'b1) begin
                data = bc ? alarm_broadcast : rd_data;
                ok = 1'b1;
            end
        end
    endtask
    // report the outcome of one finished command
    task automatic command(input logic [2:0] outcome);
        @(negedge clock);
        cmd_done = 1'b1;
        cmd_outcome = outcome;
        @(negedge clock);
        cmd_done = 1'b0;
        cmd_outcome = ~outcome;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import pack_status_pkg::*;
;
    // ==========================================================
    // bench-driven gauge measurements, nominal half-full pack
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [15:0] charge_left_mah = 16'h01F4, charge_left_10mwh = 16'h01F4;
    logic [15:0] full_capacity_mah = 16'h03E8, full_capacity_10mwh = 16'h03E8;
    logic [15:0] mean_runtime_left_i = 16'h0064, mean_runtime_left_p = 16'h0064;
    logic [15:0] runtime_now_i = 16'h0064, runtime_now_p = 16'h0064;
    logic [15:0] charge_left_threshold = 16'h0064, runtime_threshold = 16'h000A;
    logic [15:0] overcharge_margin = 16'h0064, accumulated_charge = 16'h0000;
    logic [15:0] temperature = 16'h00FA, suspend_temp_low = 16'h0000;
    logic [15:0] ot_charge_set = 16'h01C2, ot_charge_reset = 16'h0190;
    logic [15:0] ot_discharge_set = 16'h0258, ot_discharge_reset = 16'h0226;
    logic [15:0] pack_voltage = 16'h2EE0, terminate_voltage = 16'h2328;
    logic [15:0] single_cell_voltage = 16'h0FA0;
    logic [15:0] second_end_discharge_threshold = 16'h0BB8;
    logic [15:0] requested_charge_voltage_mv = 16'h3A98;
    logic [15:0] cycle_load_value = 16'hFFFD;
    logic capacity_units_mode = 1'b0, charging = 1'b0, cv_out_of_range = 1'b0;
    logic discharge_mah_tick = 1'b0, primary_termination = 1'b0;
    logic cell_undervoltage_flag = 1'b0, below_overload_current = 1'b1;
    logic nv_load_valid = 1'b0, nv_load_bad = 1'b0;
    logic cycle_threshold_hit = 1'b0, cycle_load = 1'b0;
    logic [6:0] fully_charged_clear_pct = 7'h5A, battery_low_pct = 7'h05;
    // host-driven and design-driven nets
    wire logic rd_strobe, cmd_done, broadcast_req;
    wire logic rd_valid, alarm_broadcast_valid, cycle_save_req;
    wire logic [7:0] rd_command;
    wire logic [2:0] cmd_outcome;
    wire logic [15:0] rd_data, alarm_broadcast;
    wire logic [15:0] pack_status_word, charge_cycle_counter;
    int err_count = 0, compares = 0, saves = 0;
    logic [15:0] got;
    logic ok;
    battery_status_word_logic u_dut (.*);
    host_model u_host (.*);
    always #10 clock = ~clock;
    // count save requests towards nonvolatile storage
    always @(posedge clock) if (cycle_save_req === 1'b1) saves <= saves + 1;
    // ==========================================================
    // compare, verdict, access helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a missing answer ends the run
    task automatic get(input logic bc, input logic [7:0] cmd);
        u_host.request(bc, cmd, got, ok);
        if (!ok) begin
            err_count++;
            results();
        end
    endtask
    // let flags settle, then read the status word
    task automatic status(input logic [15:0] exp);
        repeat (3) @(negedge clock);
        get(1'b0, CMD_STATUS_WORD);
        check(got, exp);
        check(pack_status_word, exp);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(negedge clock);
        rst = 1'b0;
        status(16'h0040);
        get(1'b0, CMD_CYCLE_COUNT);
        check(got, 16'h0000);
        get(1'b0, CMD_CHARGE_VOLTAGE);
        check(got, 16'h3A98);
        cv_out_of_range = 1'b1;
        get(1'b0, CMD_CHARGE_VOLTAGE);
        check(got, 16'hFFFF);
        pulse(nv_load_valid);
        status(16'h00C0);
        pulse(nv_load_bad);
        status(16'h0040);
        // every outcome class lands in the error field
        for (int k = 0; k < 8; k++) begin
            u_host.command(3'(k));
            status(16'h0040 | 16'(k));
        end
        u_host.command(3'h0);
        get(1'b1, 8'h00);
        check(got, 16'h0047);
        charge_left_mah = 16'h0032;
        status(16'h0240);
        capacity_units_mode = 1'b1;
        status(16'h0040);
        capacity_units_mode = 1'b0;
        charge_left_mah = 16'h01F4;
        runtime_now_i = 16'h0005;
        mean_runtime_left_i = 16'h0005;
        status(16'h0140);
        runtime_now_i = 16'h0064;
        mean_runtime_left_i = 16'h0064;
        temperature = 16'h0258;
        status(16'h1040);
        temperature = 16'h0230;
        status(16'h1040);
        temperature = 16'h00FA;
        status(16'h0040);
        charge_left_mah = 16'h0000;
        status(16'h0A50);
        charge_left_mah = 16'h0064;
        status(16'h0250);
        charge_left_mah = 16'h00C8;
        status(16'h0040);
        // cell undervoltage raises the discharge-termination alarm, a low cell the fully-discharged flag
        cell_undervoltage_flag = 1'b1;
        single_cell_voltage = 16'h0800;
        status(16'h0850);
        cell_undervoltage_flag = 1'b0;
        single_cell_voltage = 16'h0FA0;
        status(16'h0040);
        charge_left_mah = 16'h03B6;
        charging = 1'b1;
        primary_termination = 1'b1;
        status(16'h4020);
        primary_termination = 1'b0;
        charging = 1'b0;
        status(16'h0060);
        charge_left_mah = 16'h01F4;
        status(16'h0040);
        charging = 1'b1;
        accumulated_charge = 16'h04B0;
        status(16'h8020);
        charging = 1'b0;
        accumulated_charge = 16'h0000;
        pulse(discharge_mah_tick);
        status(16'h8060);
        pulse(discharge_mah_tick);
        status(16'h0040);
        pulse(cycle_load);
        pulse(cycle_threshold_hit);
        repeat (3) @(negedge clock);
        check(charge_cycle_counter, 16'hFFFE);
        pulse(cycle_threshold_hit);
        pulse(cycle_threshold_hit);
        get(1'b0, CMD_CYCLE_COUNT);
        check(got, 16'hFFFF);
        check(16'(saves), 16'h0002);
        results();
    end
endmodule
`default_nettype wire
